// File: rtl/gpio_bank_cfg.svh
// offsets, field positions, reset values and counts of the port data bank
`ifndef GPIO_BANK_CFG_SVH
`define GPIO_BANK_CFG_SVH

// number of port slots, six banks of eight bit positions
`define GPIO_PORT_COUNT     48
// ports that exist; bank one sits in the low byte
`define GPIO_PORT_MASK      48'h03FF_0FFF_F7FF
// bus byte address width and data width
`define GPIO_ADDR_W         9
`define GPIO_DATA_W         32

// data register indices, relative to the wake event block base
`define GPIO_DATA_BANK_ONE   7'h4B
`define GPIO_DATA_BANK_TWO   7'h4C
`define GPIO_DATA_BANK_THREE 7'h4D
`define GPIO_DATA_BANK_FOUR  7'h4E
`define GPIO_DATA_BANK_FIVE  7'h4F
`define GPIO_DATA_BANK_SIX   7'h50

// first configuration register index of each bank
`define GPIO_CFG_BANK_ONE    7'h23
`define GPIO_CFG_BANK_TWO    7'h2B
`define GPIO_CFG_BANK_THREE  7'h33
`define GPIO_CFG_BANK_FOUR   7'h3B
`define GPIO_CFG_BANK_FIVE   7'h3F
`define GPIO_CFG_BANK_SIX    7'h47

// configuration field positions
`define GPIO_CFG_DIR_BIT     0
`define GPIO_CFG_POL_BIT     1
`define GPIO_CFG_ODRAIN_BIT  7

// reset values
`define GPIO_CFG_RESET       8'h01
`define GPIO_DATA_RESET      1'b0

`endif

// File: rtl/gpio_bank_pkg.sv
// types shared by the port data bank
package gpio_bank_pkg;

  // bus access sequencer states
  typedef enum logic [0:0]
  {
    ACC_IDLE,
    ACC_DONE
  } acc_state_t;

  // pin direction as held in configuration bit 0
  typedef enum logic
  {
    DIR_OUTPUT,
    DIR_INPUT
  } port_dir_t;

endpackage

// File: rtl/gpio_data_register_bank.sv
// general purpose port data and configuration registers behind an avalon slave
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/100ps
`include "gpio_bank_cfg.svh"

module gpio_data_register_bank
  import gpio_bank_pkg::*;
#(
  parameter int         PORTS     = `GPIO_PORT_COUNT,
  parameter logic [7:0] CFG_RESET = `GPIO_CFG_RESET
)
(
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic [`GPIO_ADDR_W-1:0]  avs_address_i,
  input  wire logic                     avs_read_i,
  input  wire logic                     avs_write_i,
  input  wire logic [`GPIO_DATA_W-1:0]  avs_writedata_i,
  input  wire logic [3:0]               avs_byteenable_i,
  output logic      [`GPIO_DATA_W-1:0]  avs_readdata_o,
  output logic                          avs_waitrequest_o,
  input  wire logic [PORTS-1:0]         pin_i,
  output logic      [PORTS-1:0]         pin_o,
  output logic      [PORTS-1:0]         pin_oe_n_o
);

  // existing ports; absent slots are reserved positions
  localparam logic [`GPIO_PORT_COUNT-1:0] PORT_MASK = `GPIO_PORT_MASK;

  // refuse a port count the fixed map cannot serve
  generate
    if (PORTS != `GPIO_PORT_COUNT)
    begin : g_bad_ports
      $error("PORTS must equal the fixed port map size");
    end
  endgenerate

  // reset synchroniser stages
  logic                     rst_meta_reg;    // first stage, read only by second
  logic                     rst_sync_reg;    // released reset used by the design
  logic                     rst_n;           // internal active low reset

  // register state
  logic [PORTS-1:0][7:0]    cfg_reg;         // per-port configuration byte
  logic [PORTS-1:0]         data_reg;        // per-port written data bit
  logic [PORTS-1:0]         pin_out_reg;     // registered pin value
  logic [PORTS-1:0]         pin_oe_n_reg;    // registered pin enable, low drives

  // bus sequencer
  acc_state_t               acc_state_reg;   // idle or answering
  logic [`GPIO_DATA_W-1:0]  rdata_reg;       // latched read answer
  logic                     wait_reg;        // waitrequest flop

  // decode results
  logic [6:0]               acc_index;       // register index of this access
  logic                     hit_data;        // a data bank is addressed
  logic                     hit_cfg;         // a configuration byte is addressed
  logic [2:0]               hit_bank;        // addressed data bank
  logic [5:0]               hit_port;        // addressed configuration port
  logic                     wr_commit;       // write completes this edge
  logic                     rd_accept;       // read is latched this edge

  // per-port views
  logic [PORTS-1:0]         rd_view;         // value software sees per port
  logic [PORTS-1:0]         is_input;        // port configured as input
  logic [PORTS-1:0]         is_inverted;     // port polarity inverted
  logic [7:0]               rd_byte;         // byte answered for this access

  // first configuration index of a bank
  function automatic logic [6:0] cfg_bank_base(input logic [2:0] bank);
    logic [6:0] base;
    base = `GPIO_CFG_BANK_ONE;
    unique case (bank)
      3'h0:    base = `GPIO_CFG_BANK_ONE;
      3'h1:    base = `GPIO_CFG_BANK_TWO;
      3'h2:    base = `GPIO_CFG_BANK_THREE;
      3'h3:    base = `GPIO_CFG_BANK_FOUR;
      3'h4:    base = `GPIO_CFG_BANK_FIVE;
      3'h5:    base = `GPIO_CFG_BANK_SIX;
      default: base = `GPIO_CFG_BANK_ONE;
    endcase
    return base;
  endfunction

  // configuration index of a port slot
  function automatic logic [6:0] cfg_index(input int port);
    logic [6:0] idx;
    idx = 7'(cfg_bank_base(3'(port / 8)) + 7'(port % 8));
    return idx;
  endfunction

  // reset release through two flops
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // word index; byte lanes below the word are ignored
  assign acc_index = avs_address_i[`GPIO_ADDR_W-1:2];

  // address decode for data banks and configuration bytes
  always_comb
  begin
    hit_data = 1'b0;
    hit_cfg  = 1'b0;
    hit_bank = 3'h0;
    hit_port = 6'h00;
    if (acc_index >= `GPIO_DATA_BANK_ONE && acc_index <= `GPIO_DATA_BANK_SIX)
    begin
      hit_data = 1'b1;
      hit_bank = 3'(acc_index - `GPIO_DATA_BANK_ONE);
    end
    // one configuration byte per existing port
    for (int p = 0; p < PORTS; p++)
    begin
      if (PORT_MASK[p] && acc_index == cfg_index(p))
      begin
        hit_cfg  = 1'b1;
        hit_port = 6'(p);
      end
    end
  end

  // reads latch on entry, writes land on the waitrequest-low edge
  assign rd_accept = (acc_state_reg == ACC_IDLE) && avs_read_i;
  assign wr_commit = (acc_state_reg == ACC_DONE) && avs_write_i;

  // per-port view, polarity and direction
  generate
    for (genvar p = 0; p < PORTS; p++)
    begin : g_view
      // bit 0 direction, bit 1 polarity
      assign is_input[p]    = cfg_reg[p][`GPIO_CFG_DIR_BIT] == DIR_INPUT;
      assign is_inverted[p] = cfg_reg[p][`GPIO_CFG_POL_BIT];
      if (PORT_MASK[p])
      begin : g_live
        assign rd_view[p] = is_input[p] ? (pin_i[p] ^ is_inverted[p]) : data_reg[p];
      end
      else
      begin : g_hole
        assign rd_view[p] = 1'b0;
      end
    end
  endgenerate

  // byte view of the addressed bank
  // fourth bank upper nibble is reserved
  // fifth bank carries all eight bits
  assign rd_byte = hit_data ? rd_view[{hit_bank, 3'h0} +: 8]
                 : hit_cfg  ? cfg_reg[hit_port]
                 : 8'h00;

  // bus timing seen from the master:
  // - a request is taken at the first edge that finds it
  //   raised while the sequencer is idle
  // - waitrequest then goes low for exactly one cycle
  // - the master completes at the next edge and must have
  //   held address, direction and write data unchanged
  //   until then
  // - reads are latched when the request is taken, so the
  //   answer reflects the pin level at acceptance, not at
  //   completion; this keeps the answer stable for the
  //   whole low cycle of waitrequest
  // - writes land only at the completion edge, so a write
  //   that a master abandons early never changes state
  // - the sequencer always returns to idle after the low
  //   cycle, which gives at least one high cycle of
  //   waitrequest between two accesses
  // - unmapped indices answer with the same timing and
  //   read zero, so software never stalls on a hole
  //
  // hazards a user must know:
  // - there is no error response; a stray write to a
  //   hole is silently dropped
  // - only byte lane zero carries data; upper lanes of
  //   write data are ignored and read back as zero
  // - a write with byte enable zero clear changes
  //   nothing but still completes normally
  // - address bits 1:0 are ignored, so any byte address
  //   inside a word reaches the same register
  //
  // pin side:
  // - pin drive and pin enable follow one edge after the
  //   write that changes them, since both are registered
  // - a port switched from input to output drives the
  //   data bit it held before; software that cares writes
  //   the data bit first is not possible, because writes
  //   to an input port are ignored, so it must accept the
  //   stored value or set polarity to suit
  // - open drain only ever pulls low; a high level then
  //   comes from the board
  //
  // trade-offs:
  // - one fixed wait cycle per access costs bandwidth but
  //   keeps read data registered straight from a flop
  // - the full configuration byte is stored even though
  //   only three bits act, so software reads back what it
  //   wrote

  // access sequencer, one wait cycle per access
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_state_reg <= ACC_IDLE;
      wait_reg      <= 1'b1;
    end
    else
    begin
      unique case (acc_state_reg)
        // request seen: release waitrequest next cycle
        ACC_IDLE:
        begin
          if (avs_read_i || avs_write_i)
          begin
            acc_state_reg <= ACC_DONE;
            wait_reg      <= 1'b0;
          end
        end
        // master completes here; raise waitrequest again
        ACC_DONE:
        begin
          acc_state_reg <= ACC_IDLE;
          wait_reg      <= 1'b1;
        end
      endcase
    end
  end

  // read answer latched when the read is taken
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= '0;
    end
    else if (rd_accept)
    begin
      // addressed data or configuration byte latched at the read
      rdata_reg <= {24'h000000, rd_byte};
    end
  end

  // per-port configuration and data storage
  generate
    for (genvar p = 0; p < PORTS; p++)
    begin : g_port
      if (PORT_MASK[p])
      begin : g_live
        // configuration byte, written whole
        always_ff @(posedge core_clk_i or negedge rst_n)
        begin
          if (!rst_n)
          begin
            cfg_reg[p] <= CFG_RESET;
          end
          else if (wr_commit && hit_cfg && avs_byteenable_i[0] && hit_port == 6'(p))
          begin
            cfg_reg[p] <= avs_writedata_i[7:0];
          end
        end

        // data bit, only taken while the port drives
        always_ff @(posedge core_clk_i or negedge rst_n)
        begin
          if (!rst_n)
          begin
            data_reg[p] <= `GPIO_DATA_RESET;
          end
          else if (wr_commit && hit_data && avs_byteenable_i[0] && hit_bank == 3'(p / 8)
                   && !is_input[p])
          begin
            data_reg[p] <= avs_writedata_i[p % 8];
          end
        end

        // pin drive, registered so outputs come from flops
        always_ff @(posedge core_clk_i or negedge rst_n)
        begin
          if (!rst_n)
          begin
            pin_out_reg[p]  <= 1'b0;
            pin_oe_n_reg[p] <= 1'b1;
          end
          else if (is_input[p])
          begin
            // input: release the pin
            pin_out_reg[p]  <= 1'b0;
            pin_oe_n_reg[p] <= 1'b1;
          end
          else
          begin
            pin_out_reg[p]  <= data_reg[p] ^ is_inverted[p];
            // open drain only pulls low, push-pull always drives
            pin_oe_n_reg[p] <= cfg_reg[p][`GPIO_CFG_ODRAIN_BIT] && (data_reg[p] ^ is_inverted[p]);
          end
        end
      end
      else
      begin : g_hole
        // reserved slot holds nothing and never drives
        assign cfg_reg[p]      = 8'h00;
        assign data_reg[p]     = 1'b0;
        assign pin_out_reg[p]  = 1'b0;
        assign pin_oe_n_reg[p] = 1'b1;
      end
    end
  endgenerate

  // outputs straight from flops
  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign pin_o             = pin_out_reg;
  assign pin_oe_n_o        = pin_oe_n_reg;

endmodule

// File: test/gpio_data_register_bank_props.sv
// concurrent checks on the ports of the port data bank
`timescale 1ns/100ps
`include "gpio_bank_cfg.svh"
module gpio_data_register_bank_props
#(
  parameter int PORTS = 48
)
(
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [`GPIO_DATA_W-1:0] avs_readdata_o,
  input  wire logic                    avs_waitrequest_o,
  input  wire logic [PORTS-1:0]        pin_o,
  input  wire logic [PORTS-1:0]        pin_oe_n_o
);
  // slots with no port behind them
  localparam logic [PORTS-1:0] EMPTY = ~PORTS'(`GPIO_PORT_MASK);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // request taken by an idle sequencer
  sequence s_take;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  // one low cycle of waitrequest, then high again
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  chk_ack_pulse: assert property (s_take |=> s_ack)
    else $error("access not answered by a single wait low cycle");
  chk_ack_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("wait low without a request");
  chk_rd_upper: assert property (avs_readdata_o[31:8] == '0)
    else $error("read data upper lanes not zero");
  chk_rd_latched: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i) && $past(avs_waitrequest_o))
    else $error("read data moved without a read");
  chk_empty_pin: assert property ((pin_o & EMPTY) == '0)
    else $error("empty slot drives a value");
  chk_empty_oe: assert property ((pin_oe_n_o & EMPTY) == EMPTY)
    else $error("empty slot enabled");
  chk_pin_cause: assert property ($changed(pin_o) |-> $past(avs_write_i, 2))
    else $error("pin drive moved without a write");
  chk_oe_cause: assert property ($changed(pin_oe_n_o) |-> $past(avs_write_i, 2))
    else $error("pin enable moved without a write");
endmodule

bind gpio_data_register_bank gpio_data_register_bank_props #(.PORTS(PORTS)) u_props
(
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o)
);

// File: test/gpio_data_register_bank_tb_top.sv
// self-checking bench for the port data bank
`timescale 1ns/100ps
`include "gpio_bank_cfg.svh"
module gpio_data_register_bank_tb_top;
  import gpio_bank_pkg::*;
  localparam logic [47:0] MASK = `GPIO_PORT_MASK;
  // first configuration index of each bank
  localparam logic [6:0] CFG_BASE [6] = '{`GPIO_CFG_BANK_ONE, `GPIO_CFG_BANK_TWO, `GPIO_CFG_BANK_THREE,
                                          `GPIO_CFG_BANK_FOUR, `GPIO_CFG_BANK_FIVE, `GPIO_CFG_BANK_SIX};
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic [8:0]  addr     = '0;
  logic        rd       = 1'b0;
  logic        wr       = 1'b0;
  logic [31:0] wdata    = '0;
  logic [47:0] pins     = '0;
  logic [31:0] rdata;
  logic        wait_req;
  logic [47:0] pin_o;
  logic [47:0] oe_n;
  logic [47:0] is_in    = '1;  // model: direction per slot
  logic [47:0] pol      = '0;  // model: polarity per slot
  logic [47:0] od       = '0;  // model: open drain per slot
  logic [3:0]  be       = 4'h1; // byte enables driven to the design
  logic [47:0] dat      = '0;  // model: stored data bits
  logic [7:0]  expq [$];       // expected read values, oldest first
  logic [31:0] seed     = 32'h26;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc      = 0;
  // expected read value of every slot
  wire logic [47:0] exp_v = MASK & ((is_in & (pins ^ pol)) | (~is_in & dat));

  gpio_data_register_bank u_gpio_data_register_bank
  (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .pin_i(pins), .pin_o(pin_o), .pin_oe_n_o(oe_n)
  );

  // 100 ns clock
  always #50 core_clk = ~core_clk;

  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cmp(input string nm, input logic [47:0] e, input logic [47:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one bus access; reads leave their expected value in the queue
  task automatic acc(input logic w, input logic [6:0] idx, input logic [7:0] d, input logic [7:0] e);
    @(posedge core_clk);
    addr  <= {idx, 2'b00};
    wdata <= {24'h0, d};
    rd    <= !w;
    wr    <= w;
    if (!w)
      expq.push_back(e);
    @(posedge core_clk iff !wait_req);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // watcher: timeout and read data at completion
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_errors++;
      stop_test();
    end
    if (rd && !wait_req && expq.size() > 0)
      cmp("readdata", 48'(expq.pop_front()), 48'(rdata));
  end

  initial
  begin
    logic [7:0] d;
    pins = 48'({rnd(), rnd()});
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmp("pin_oe_n", '1, oe_n);
    for (int r = 0; r < 3; r++)
    begin
      for (int b = 0; b < 6; b++)
      begin
        d = rnd();
        acc(1'b1, 7'(`GPIO_DATA_BANK_ONE + b), d, 8'h00);
        dat[b*8+:8] = (dat[b*8+:8] & is_in[b*8+:8]) | (d & ~is_in[b*8+:8]);
      end
      repeat (2) @(posedge core_clk);
      cmp("pin_o", ~is_in & (dat ^ pol), pin_o);
      cmp("pin_oe_n", is_in | (~is_in & od & (dat ^ pol)), oe_n);
      for (int b = 0; b < 6; b++)
        acc(1'b0, 7'(`GPIO_DATA_BANK_ONE + b), 8'h00, exp_v[b*8+:8]);
      pins <= 48'({rnd(), rnd()});
      for (int s = 0; s < 48; s++)
        if (MASK[s])
        begin
          d = rnd() & 8'h83;
          acc(1'b1, 7'(CFG_BASE[s/8] + s%8), d, 8'h00);
          acc(1'b0, 7'(CFG_BASE[s/8] + s%8), 8'h00, d);
          is_in[s] = d[0];
          pol[s] = d[1];
          od[s] = d[7];
        end
    end
    acc(1'b0, 7'h7F, 8'h00, 8'h00);
    acc(1'b1, 7'h2E, 8'hFF, 8'h00);
    acc(1'b0, 7'h2E, 8'h00, 8'h00);
    // a write with lane zero disabled changes nothing
    be <= 4'h0;
    acc(1'b1, `GPIO_CFG_BANK_ONE, 8'hA5, 8'h00);
    be <= 4'h1;
    acc(1'b0, `GPIO_CFG_BANK_ONE, 8'h00, {od[0], 5'h00, pol[0], is_in[0]});
    repeat (3) @(posedge core_clk);
    stop_test();
  end
endmodule
